/* File: shared/mcc_pkg.sv */
// Operation
// R1: Each peripheral request enables its routed clock source automatically; here a routed crystal source also needs its xtal_en bit set.
// R2: Prescaler sits between main clock and peripheral clock, factor 1 to 64.
// R3: Main clock runs in active and idle; in standby only when requested.
// R4: CPU and peripheral clocks derive from main; peripheral clock may drive out.
// R5: Counter clock requested when counter or timer enabled; source fixed meanwhile.
// R6: Watchdog clock requested and supplied whenever the watchdog is enabled.
// R7: Brown-out clock requested only in sampled mode; alternative source from fuse.
// R8: Failure monitor on external sources falls back to the internal fast oscillator.
// R9: Source select writes take effect only after the protect key unlock.
// R10: Any of five sources may be selected and switched safely at run time.
// R11: Software configures and enables a crystal source before selecting it.
// R12: Keep-in-standby bit holds a source running; software polls its stable flag.
// R13: Control B holds division field and enable; divides only while enable is one.
// R14: Software orders prescaler and select updates to stay under maximum frequency.
// R15: Switch-pending flag stands while a source change is under way.
// R16: After reset main clock is the internal fast oscillator divided by six.
// R17: External switch needs enough edges; otherwise old source kept, changes locked.
// R18: With prescaler disabled, CPU and peripheral clocks equal the main clock.
package mcc_pkg;
   localparam int          CLK_PERIOD_NS    = 20;
   localparam int          NUM_SRC          = 5;
   localparam int          ADDR_W           = 4;
   localparam logic [3:0]  OFS_KEY          = 4'h0;
   localparam logic [3:0]  OFS_CTRL_A       = 4'h1;
   localparam logic [3:0]  OFS_CTRL_B       = 4'h2;
   localparam logic [3:0]  OFS_CTRL_C       = 4'h3;
   localparam logic [3:0]  OFS_STATUS       = 4'h4;
   localparam logic [3:0]  OFS_FLAGS        = 4'h5;
   localparam logic [3:0]  OFS_MASK         = 4'h6;
   localparam logic [3:0]  OFS_XTAL_EN      = 4'h7;
   localparam logic [3:0]  OFS_STBY         = 4'h8;
   localparam logic [7:0]  PROTECT_KEY      = 8'hD8;
   localparam logic [2:0]  UNLOCK_CYCLES    = 3'h4;
   localparam logic [2:0]  SRC_IFAST        = 3'h0;
   localparam logic [2:0]  SRC_ISLOW        = 3'h1;
   localparam logic [2:0]  SRC_XSLOW        = 3'h2;
   localparam logic [2:0]  SRC_XFAST        = 3'h3;
   localparam logic [2:0]  SRC_EXT          = 3'h4;
   localparam int          CTRLA_OUT_BIT    = 7;
   localparam int          CTRLB_ON_BIT     = 0;
   localparam int          CTRLB_DIV_LSB    = 1;
   localparam int          FLAG_FAIL        = 0;
   localparam int          FLAG_DONE        = 1;
   localparam int          FLAG_LOCK        = 2;
   localparam logic [2:0]  SEL_RST          = SRC_IFAST;
   localparam logic        PSCL_ON_RST      = 1'b1;
   localparam logic [3:0]  DIV_CODE_RST     = 4'h8;
   localparam int          SWITCH_WINDOW_NS = 2000;
   localparam int          SWITCH_WINDOW    = SWITCH_WINDOW_NS / CLK_PERIOD_NS;
   localparam int          SWITCH_EDGES     = 4;
   localparam int          FAIL_WINDOW_NS   = 1000;
   localparam int          FAIL_WINDOW      = FAIL_WINDOW_NS / CLK_PERIOD_NS;
   // Division factor per code; reserved codes fall back to two
   localparam logic [15:0][6:0] DIV_FACTOR = {
      7'h02, 7'h02, 7'h02, 7'h30, 7'h18, 7'h0C, 7'h0A, 7'h06,
      7'h02, 7'h02, 7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02};
   typedef enum logic [1:0] {MCC_ACTIVE, MCC_IDLE, MCC_STANDBY} mcc_power_type;
endpackage

/* File: verilog/mcc_edge_monitor.sv */
module mcc_edge_monitor
   import mcc_pkg::*;
#(
   parameter int WINDOW    = SWITCH_WINDOW,
   parameter int MIN_EDGES = SWITCH_EDGES
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Watch request and source edge
   input  wire logic run,
   input  wire logic edge_seen,
   // Verdicts, one cycle each
   output logic      pass_q,
   output logic      fail_q
);
   localparam int CW = $clog2(WINDOW + 1);
   typedef struct packed {
      logic          active;
      logic [CW-1:0] cnt;
      logic [CW-1:0] edges;
      logic          pass;
      logic          fail;
   } mcc_mon_type;
   mcc_mon_type s_q, s_d;

   always_comb begin
      s_d      = s_q;
      s_d.pass = 1'b0;
      s_d.fail = 1'b0;
      if (!run) begin
         s_d.active = 1'b0;
      end else if (!s_q.active) begin
         s_d.active = 1'b1;
         s_d.cnt    = '0;
         s_d.edges  = '0;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
         if (edge_seen) begin
            s_d.edges = s_q.edges + 1'b1;
         end
         // Edge count wins over a window expiring in the same cycle
         if (edge_seen && s_q.edges == CW'(MIN_EDGES - 1)) begin
            s_d.pass   = 1'b1;
            s_d.active = 1'b0;
         end else if (s_q.cnt == CW'(WINDOW - 1)) begin
            s_d.fail   = 1'b1;
            s_d.active = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pass_q = s_q.pass;
   assign fail_q = s_q.fail;

   a_fail_at_window: assert property (@(posedge core_clk) disable iff (rst) // [R17]
      s_q.fail |-> $past(s_q.cnt) == CW'(WINDOW - 1))
      else $error("monitor failed before its window ran out");
endmodule // mcc_edge_monitor

/* File: verilog/mcc_prescaler.sv */
module mcc_prescaler
   import mcc_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Main clock gate and settings
   input  wire logic       run,
   input  wire logic       pscl_on,
   input  wire logic [3:0] div_code,
   // Divided clock enable
   output logic            tick_q
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       tick;
   } mcc_pscl_type;
   mcc_pscl_type s_q, s_d;
   logic [5:0] last;

   assign last = 6'(DIV_FACTOR[div_code] - 7'h01);

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (run) begin
         if (!pscl_on) begin
            s_d.tick = 1'b1; // [R18]
            s_d.cnt  = '0;
         end else if (s_q.cnt >= last) begin
            s_d.tick = 1'b1; // [R2]
            s_d.cnt  = '0;
         end else begin
            s_d.cnt = s_q.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_q = s_q.tick;

   a_div_bypass: assert property (@(posedge core_clk) disable iff (rst) // [R18]
      run && !pscl_on |=> tick_q)
      else $error("undivided clock missed a cycle");
   a_div_gap: assert property (@(posedge core_clk) disable iff (rst) // [R2]
      run && pscl_on && s_q.cnt < last |=> !tick_q)
      else $error("divided clock ticked early");
endmodule // mcc_prescaler

/* File: verilog/mcc_main_clock_ctrl.sv */
// The strobed register port and the placing of the registers were decided locally.
module mcc_main_clock_ctrl
   import mcc_pkg::*;
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   // Oscillators
   input  wire logic [NUM_SRC-1:0]  src_edge,
   input  wire logic [NUM_SRC-1:0]  src_stable,
   output logic      [NUM_SRC-1:0]  src_enable,
   // Power state and peripheral requests
   input  wire mcc_power_type       power_state,
   input  wire logic                main_standby_req,
   input  wire logic                counter_enable,
   input  wire logic                periodic_timer_enable,
   input  wire logic                counter_src_crystal,
   input  wire logic                watchdog_enable,
   input  wire logic                brownout_sampled,
   input  wire logic                brownout_fuse_alt,
   // Clock requests and derived clock enables
   output logic                     counter_clock_req,
   output logic                     watchdog_timer_clock,
   output logic                     brownout_sample_clock,
   output logic                     main_clock_run,
   output logic                     cpu_clock_tick,
   output logic                     peripheral_bus_clock,
   output logic                     clock_output_pin,
   // Interrupt
   output logic                     irq
);
   typedef struct packed {
      logic [7:0]         rdata;
      logic [2:0]         unlock;
      logic [2:0]         sel_cur;
      logic [2:0]         sel_tgt;
      logic               pending;
      logic               locked;
      logic               out_en;
      logic               pscl_on;
      logic [3:0]         div_code;
      logic               mon_en;
      logic [NUM_SRC-1:0] xtal_en;
      logic [NUM_SRC-1:0] stby;
      logic [2:0]         flags;
      logic [2:0]         mask;
      logic               irq;
      logic [NUM_SRC-1:0] src_en;
      logic               ctr_crystal;
      logic               ctr_req;
      logic               wdt_req;
      logic               bod_req;
      logic               run;
      logic               out_pin;
   } mcc_state_type;
   mcc_state_type s_q, s_d;

   logic       per_tick;
   logic       sw_pass;
   logic       sw_fail;
   logic       fail_pass;
   logic       fail_seen;
   logic       tgt_ext;
   logic       cur_ext;
   logic       wr_ok;
   logic [2:0] new_sel;
   logic [2:0] ctr_src;
   logic [2:0] bod_src;

   assign tgt_ext = s_q.sel_tgt >= SRC_XSLOW;
   assign cur_ext = s_q.sel_cur >= SRC_XSLOW;
   assign wr_ok   = reg_wr && s_q.unlock != 3'h0;
   assign new_sel = reg_wdata[2:0];
   assign ctr_src = s_q.ctr_crystal ? SRC_XSLOW : SRC_ISLOW;
   assign bod_src = brownout_fuse_alt ? SRC_XSLOW : SRC_ISLOW;

   mcc_prescaler u_prescaler (
      .core_clk (core_clk),
      .rst      (rst),
      .run      (s_q.run),
      .pscl_on  (s_q.pscl_on),
      .div_code (s_q.div_code),
      .tick_q   (per_tick)
   );

   // Edge check on the target before the switch is committed
   mcc_edge_monitor #(
      .WINDOW    (SWITCH_WINDOW),
      .MIN_EDGES (SWITCH_EDGES)
   ) u_switch_mon (
      .core_clk  (core_clk),
      .rst       (rst),
      .run       (s_q.pending && tgt_ext),
      .edge_seen (src_edge[s_q.sel_tgt]),
      .pass_q    (sw_pass),
      .fail_q    (sw_fail)
   );

   // One edge per window keeps the running external source trusted
   mcc_edge_monitor #(
      .WINDOW    (FAIL_WINDOW),
      .MIN_EDGES (1)
   ) u_fail_mon (
      .core_clk  (core_clk),
      .rst       (rst),
      .run       (s_q.mon_en && cur_ext && !s_q.pending && s_q.run),
      .edge_seen (src_edge[s_q.sel_cur]),
      .pass_q    (fail_pass),
      .fail_q    (fail_seen)
   );

   always_comb begin
      s_d       = s_q;
      s_d.rdata = 8'h00;

      // Key opens a short window for one protected write
      if (reg_wr && reg_addr == OFS_KEY && reg_wdata == PROTECT_KEY) begin
         s_d.unlock = UNLOCK_CYCLES; // [R9]
      end else if (wr_ok && reg_addr inside {OFS_CTRL_A, OFS_CTRL_B, OFS_CTRL_C}) begin
         s_d.unlock = 3'h0;
      end else if (s_q.unlock != 3'h0) begin
         s_d.unlock = s_q.unlock - 3'h1;
      end

      if (wr_ok && reg_addr == OFS_CTRL_A) begin
         s_d.out_en = reg_wdata[CTRLA_OUT_BIT];
         // Ignored while a switch runs or after a failed one
         if (new_sel <= SRC_EXT && new_sel != s_q.sel_cur
             && !s_q.pending && !s_q.locked) begin
            s_d.sel_tgt = new_sel; // [R9] [R10]
            s_d.pending = 1'b1; // [R15]
         end
      end
      if (wr_ok && reg_addr == OFS_CTRL_B) begin
         s_d.pscl_on  = reg_wdata[CTRLB_ON_BIT]; // [R13]
         s_d.div_code = reg_wdata[CTRLB_DIV_LSB +: 4];
      end
      if (wr_ok && reg_addr == OFS_CTRL_C) begin
         s_d.mon_en = reg_wdata[0];
      end
      if (reg_wr && reg_addr == OFS_MASK) begin
         s_d.mask = reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == OFS_XTAL_EN) begin
         s_d.xtal_en = reg_wdata[NUM_SRC-1:0];
      end
      if (reg_wr && reg_addr == OFS_STBY) begin
         s_d.stby = reg_wdata[NUM_SRC-1:0]; // [R12]
      end

      // Read of the flags clears them; a new event the same cycle survives
      if (reg_rd && reg_addr == OFS_FLAGS) begin
         s_d.flags = 3'h0;
      end

      if (s_q.pending) begin
         if (!tgt_ext || sw_pass) begin
            s_d.sel_cur              = s_q.sel_tgt; // [R10]
            s_d.pending              = 1'b0; // [R15]
            s_d.flags[FLAG_DONE]     = 1'b1;
         end else if (sw_fail) begin
            s_d.pending              = 1'b0; // [R17]
            s_d.locked               = 1'b1;
            s_d.flags[FLAG_LOCK]     = 1'b1;
         end
      end else if (fail_seen) begin
         s_d.sel_cur                 = SRC_IFAST; // [R8]
         s_d.flags[FLAG_FAIL]        = 1'b1;
      end

      // Counter source may only move while counter and timer are off
      if (!(counter_enable || periodic_timer_enable)) begin
         s_d.ctr_crystal = counter_src_crystal; // [R5]
      end
      s_d.ctr_req = counter_enable || periodic_timer_enable; // [R5]
      s_d.wdt_req = watchdog_enable; // [R6]
      s_d.bod_req = brownout_sampled; // [R7]

      s_d.run = power_state != MCC_STANDBY || main_standby_req
                || s_q.stby[s_q.sel_cur]; // [R3]

      for (int i = 0; i < NUM_SRC; i++) begin
         s_d.src_en[i] = (s_q.sel_cur == 3'(i))
                      || (s_q.pending && s_q.sel_tgt == 3'(i))
                      || s_q.stby[i]
                      || (s_d.ctr_req && ctr_src == 3'(i))
                      || (s_d.wdt_req && SRC_ISLOW == 3'(i))
                      || (s_d.bod_req && bod_src == 3'(i)); // [R1] [R7]
         // Crystals start only after software enables them
         if (3'(i) >= SRC_XSLOW && !s_q.xtal_en[i]) begin
            s_d.src_en[i] = 1'b0;
         end
      end

      s_d.out_pin = per_tick && s_q.out_en; // [R4]
      s_d.irq     = |(s_d.flags & s_q.mask);

      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CTRL_A:  s_d.rdata = {s_q.out_en, 4'h0, s_q.sel_cur};
            OFS_CTRL_B:  s_d.rdata = {3'h0, s_q.div_code, s_q.pscl_on};
            OFS_CTRL_C:  s_d.rdata = {7'h00, s_q.mon_en};
            OFS_STATUS:  s_d.rdata = {1'b0, s_q.locked, src_stable, s_q.pending};
            OFS_FLAGS:   s_d.rdata = {5'h00, s_q.flags};
            OFS_MASK:    s_d.rdata = {5'h00, s_q.mask};
            OFS_XTAL_EN: s_d.rdata = {3'h0, s_q.xtal_en};
            OFS_STBY:    s_d.rdata = {3'h0, s_q.stby};
            default:     s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q          <= '0;
         s_q.sel_cur  <= SEL_RST; // [R16]
         s_q.sel_tgt  <= SEL_RST;
         s_q.pscl_on  <= PSCL_ON_RST;
         s_q.div_code <= DIV_CODE_RST;
         s_q.run      <= 1'b1;
         s_q.src_en   <= 5'h01;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata             = s_q.rdata;
   assign src_enable            = s_q.src_en;
   assign counter_clock_req     = s_q.ctr_req;
   assign watchdog_timer_clock  = s_q.wdt_req;
   assign brownout_sample_clock = s_q.bod_req;
   assign main_clock_run        = s_q.run;
   assign cpu_clock_tick        = per_tick; // [R4]
   assign peripheral_bus_clock  = per_tick;
   assign clock_output_pin      = s_q.out_pin;
   assign irq                   = s_q.irq;

   default clocking mcc_cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_locked_write: assert property ( // [R9]
      reg_wr && reg_addr == OFS_CTRL_B && s_q.unlock == 3'h0
      |=> $stable(s_q.pscl_on) && $stable(s_q.div_code))
      else $error("control B changed without unlock");
   a_pend_cause: assert property ( // [R15]
      $rose(s_q.pending) |-> $past(wr_ok && reg_addr == OFS_CTRL_A))
      else $error("switch started without a select write");
   a_internal_switch: assert property ( // [R10]
      s_q.pending && !tgt_ext |=> !s_q.pending && s_q.sel_cur == $past(s_q.sel_tgt))
      else $error("internal switch did not finish in one cycle");
   a_lock_keeps: assert property ( // [R17]
      s_q.pending && tgt_ext && sw_fail
      |=> s_q.locked && $stable(s_q.sel_cur) ##1 s_q.locked)
      else $error("failed switch moved the source or dropped the lock");
   a_lock_blocks: assert property ( // [R17]
      s_q.locked |-> !s_q.pending)
      else $error("switch started while locked");
   a_fail_fallback: assert property ( // [R8]
      fail_seen && !s_q.pending |=> s_q.sel_cur == SRC_IFAST && s_q.flags[FLAG_FAIL])
      else $error("no fallback after source failure");
   a_awake_runs: assert property ( // [R3]
      power_state != MCC_STANDBY |=> main_clock_run)
      else $error("main clock stopped while awake");
   a_standby_stop: assert property ( // [R3]
      power_state == MCC_STANDBY && !main_standby_req && !s_q.stby[s_q.sel_cur]
      |=> !main_clock_run)
      else $error("main clock runs in standby with no request");
   a_wdt_route: assert property ( // [R6] [R1]
      watchdog_enable |=> watchdog_timer_clock && src_enable[SRC_ISLOW])
      else $error("watchdog clock not supplied");
   a_ctr_hold: assert property ( // [R5]
      counter_clock_req && $past(counter_clock_req) |-> $stable(s_q.ctr_crystal))
      else $error("counter source moved while enabled");
   a_bod_req: assert property ( // [R7]
      brownout_sampled |=> brownout_sample_clock)
      else $error("brown-out clock not requested");
   a_out_pin: assert property ( // [R4]
      clock_output_pin |-> $past(per_tick) && $past(s_q.out_en))
      else $error("output pin pulsed without a peripheral tick");

   c_ext_switch: cover property (s_q.pending && tgt_ext ##1 sw_pass);
   c_lockout: cover property ($rose(s_q.locked));
   c_fallback: cover property (fail_seen && !s_q.pending);
   c_div64: cover property (s_q.pscl_on && s_q.div_code == 4'h5 && per_tick);
endmodule // mcc_main_clock_ctrl

/* File: testbench/mcc_osc_model.sv */
module mcc_osc_model
   import mcc_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Enables from the controller, stop commands from the bench
   input  wire logic [NUM_SRC-1:0] src_enable,
   input  wire logic [NUM_SRC-1:0] stop,
   // Oscillator outputs
   output logic      [NUM_SRC-1:0] src_edge,
   output logic      [NUM_SRC-1:0] src_stable
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt [NUM_SRC];
   int age [NUM_SRC];
   // Source i edges every i+2 cycles, so higher-numbered sources are slower
   always @(posedge core_clk or posedge rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
         // A disabled or broken source gives no edge and no stable flag
         if (rst || !src_enable[i] || stop[i]) begin
            cnt[i] <= 0;
            age[i] <= 0;
            src_edge[i] <= 1'b0;
            src_stable[i] <= 1'b0;
         end else begin
            cnt[i] <= (cnt[i] >= i + 1) ? 0 : cnt[i] + 1;
            age[i] <= (age[i] < 8) ? age[i] + 1 : age[i];
            src_edge[i] <= (cnt[i] == 0);
            src_stable[i] <= (age[i] == 8); // Start-up delay
         end
      end
   end
endmodule // mcc_osc_model

/* File: testbench/tb_top.sv */
module tb_top
   import mcc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic                core_clk, rst, reg_wr, reg_rd, irq, rd_d;
   logic [ADDR_W-1:0]   reg_addr;
   logic [7:0]          reg_wdata, reg_rdata, last;
   logic [NUM_SRC-1:0]  src_edge, src_stable, src_enable, stop;
   mcc_power_type       power_state;
   logic                main_standby_req, counter_enable, periodic_timer_enable;
   logic                counter_src_crystal, watchdog_enable, brownout_sampled;
   logic                brownout_fuse_alt, counter_clock_req, watchdog_timer_clock;
   logic                brownout_sample_clock, main_clock_run, cpu_clock_tick;
   logic                peripheral_bus_clock, clock_output_pin;
   logic [4:0]          v;
   logic [15:0]         e_w;
   logic [15:0]         exp_q [$];
   int                  n_fail, cmp_count;
   int                  fac [12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 2};
   logic [3:0]          cod [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                     4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};

   mcc_main_clock_ctrl uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .src_edge(src_edge), .src_stable(src_stable), .src_enable(src_enable),
      .power_state(power_state), .main_standby_req(main_standby_req),
      .counter_enable(counter_enable), .periodic_timer_enable(periodic_timer_enable),
      .counter_src_crystal(counter_src_crystal), .watchdog_enable(watchdog_enable),
      .brownout_sampled(brownout_sampled), .brownout_fuse_alt(brownout_fuse_alt),
      .counter_clock_req(counter_clock_req), .watchdog_timer_clock(watchdog_timer_clock),
      .brownout_sample_clock(brownout_sample_clock), .main_clock_run(main_clock_run),
      .cpu_clock_tick(cpu_clock_tick), .peripheral_bus_clock(peripheral_bus_clock),
      .clock_output_pin(clock_output_pin), .irq(irq));
   mcc_osc_model osc (.core_clk(core_clk), .rst(rst), .src_enable(src_enable),
      .stop(stop), .src_edge(src_edge), .src_stable(src_stable));

   initial begin
      core_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m,
                      input string what);
      cmp_count++;
      if ((got & m) !== (e & m)) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, e);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Key first; the write lands two edges later, inside the unlock span
   task automatic pwr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      wr(OFS_KEY, PROTECT_KEY);
      wr(a, d);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back({m, e});
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 last = reg_rdata;
   endtask

   task automatic poll(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] w);
      for (int n = 0; n < 300; n++) begin
         rd(a, 8'h00, 8'h00);
         if ((last & m) === w) break;
      end
      chk(last, w, m, "poll");
   endtask

   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   // Counts cycles up to the next tick, checking the derived clocks on the way
   task automatic wait_tick(input logic oe, output int n);
      logic prev;
      #1;
      n = 0;
      prev = peripheral_bus_clock;
      do begin
         @(posedge core_clk);
         #1;
         n++;
         chk(8'(cpu_clock_tick), 8'(peripheral_bus_clock), 8'h01, "cpu tick");
         chk(8'(clock_output_pin), 8'(prev & oe), 8'h01, "out pin");
         prev = peripheral_bus_clock;
      end while (peripheral_bus_clock !== 1'b1 && n < 200);
   endtask

   // First gap may straddle a divider change, so only the last one counts
   task automatic measure(input int per, input logic oe);
      int n;
      repeat (3) wait_tick(oe, n);
      chk(8'(n), 8'(per), 8'hFF, "tick period");
   endtask

   always @(posedge core_clk) begin
      if (rd_d && exp_q.size() > 0) begin
         e_w = exp_q.pop_front();
         if (e_w[15:8] != 8'h00) chk(reg_rdata, e_w[7:0], e_w[15:8], "read data");
      end
      rd_d = reg_rd;
   end

   initial begin
      #(30000 * CLK_PERIOD_NS);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      {rst, rd_d, reg_wr, reg_rd, reg_addr, reg_wdata, stop} = '0;
      rst = 1'b1;
      {main_standby_req, counter_enable, periodic_timer_enable, counter_src_crystal} = '0;
      {watchdog_enable, brownout_sampled, brownout_fuse_alt} = '0;
      power_state = MCC_ACTIVE;
      n_fail = 0;
      cmp_count = 0;
      void'($urandom(95670));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(OFS_CTRL_A, 8'h00, 8'h87);
      rd(OFS_CTRL_B, 8'h11, 8'h1F);
      measure(6, 1'b0);
      wr(OFS_CTRL_B, 8'h00);
      measure(6, 1'b0); // No key, no change
      pwr(OFS_CTRL_A, 8'h80);
      for (int i = 0; i < 12; i++) begin
         pwr(OFS_CTRL_B, {3'h0, cod[i], 1'b1}); // Fast clock throughout
         measure(fac[i], 1'b1);
      end
      pwr(OFS_CTRL_B, 8'h00);
      measure(1, 1'b1);
      $display("Test prescaler done");
      wr(OFS_MASK, 8'h07);
      pwr(OFS_CTRL_A, 8'h81);
      poll(OFS_STATUS, 8'h01, 8'h00);
      rd(OFS_CTRL_A, 8'h01, 8'h07);
      chk(8'(irq), 8'h01, 8'h01, "irq set");
      rd(OFS_FLAGS, 8'h02, 8'h07);
      settle();
      chk(8'(irq), 8'h00, 8'h01, "irq cleared");
      rd(OFS_FLAGS, 8'h00, 8'h07);
      rd(4'hF, 8'h00, 8'hFF);
      $display("Test internal switch done");
      wr(OFS_XTAL_EN, 8'h10);
      pwr(OFS_CTRL_A, 8'h84);
      rd(OFS_STATUS, 8'h01, 8'h01); // Pending while edges are counted
      poll(OFS_STATUS, 8'h01, 8'h00);
      rd(OFS_CTRL_A, 8'h04, 8'h07);
      rd(OFS_STATUS, 8'h20, 8'h21); // External source shows stable
      rd(OFS_FLAGS, 8'h00, 8'h00);
      pwr(OFS_CTRL_C, 8'h01);
      stop <= 5'h10;
      poll(OFS_CTRL_A, 8'h07, 8'h00); // Fallback to fast internal
      rd(OFS_FLAGS, 8'h01, 8'h01);
      stop <= 5'h00;
      $display("Test external switch done");
      wr(OFS_XTAL_EN, 8'h00);
      pwr(OFS_CTRL_A, 8'h83);
      poll(OFS_STATUS, 8'h01, 8'h00);
      rd(OFS_STATUS, 8'h40, 8'h41);
      rd(OFS_FLAGS, 8'h04, 8'h04);
      pwr(OFS_CTRL_A, 8'h81);
      rd(OFS_CTRL_A, 8'h00, 8'h07); // Locked until reset
      $display("Test failed switch done");
      wr(OFS_XTAL_EN, 8'h1C);
      for (int i = 0; i < 8; i++) begin
         v = 5'($urandom());
         {counter_enable, periodic_timer_enable, watchdog_enable} <= v[4:2];
         {brownout_sampled, brownout_fuse_alt} <= v[1:0];
         settle();
         chk(8'(counter_clock_req), 8'(v[4] | v[3]), 8'h01, "counter req");
         chk(8'(watchdog_timer_clock), 8'(v[2]), 8'h01, "watchdog clk");
         chk(8'(brownout_sample_clock), 8'(v[1]), 8'h01, "brownout clk");
         if (v[2]) chk(8'(src_enable[1]), 8'h01, 8'h01, "wdt route");
         if (v[1]) chk(8'(src_enable[v[0] ? 2 : 1]), 8'h01, 8'h01, "bod route");
      end
      $display("Test requests done");
      {counter_enable, periodic_timer_enable, watchdog_enable, brownout_sampled} <= '0;
      power_state <= MCC_STANDBY;
      settle();
      chk(8'(main_clock_run), 8'h00, 8'h01, "standby idle");
      main_standby_req <= 1'b1;
      settle();
      chk(8'(main_clock_run), 8'h01, 8'h01, "standby req");
      power_state <= MCC_IDLE;
      main_standby_req <= 1'b0;
      settle();
      chk(8'(main_clock_run), 8'h01, 8'h01, "idle run");
      power_state <= MCC_ACTIVE;
      rst <= 1'b1;
      settle();
      rst <= 1'b0;
      rd(OFS_STATUS, 8'h00, 8'h40);
      pwr(OFS_CTRL_A, 8'h01);
      poll(OFS_STATUS, 8'h01, 8'h00);
      rd(OFS_CTRL_A, 8'h01, 8'h07); // Switching free again
      $display("Test second reset done");
      end_of_test();
   end
endmodule // tb_top
